// ---- inc/wdwu_map.svh ----
`ifndef WDWU_MAP_SVH
`define WDWU_MAP_SVH

// Register byte offsets
`define WDWU_OFS_CTRL 8'h00
`define WDWU_OFS_CAUSE 8'h04
`define WDWU_OFS_STAT 8'h08
`define WDWU_OFS_WAKE_EN 8'h0C
`define WDWU_OFS_PA_DATA 8'h10
`define WDWU_OFS_PA_DIR 8'h14

// Reset values
`define WDWU_CTRL_RST 8'h53
`define WDWU_CAUSE_RST 8'h00
`define WDWU_WAKE_EN_RST 8'h00
`define WDWU_PA_RST 8'hFF

// watchdog_control fields
`define WDWU_KEY_MSB 7
`define WDWU_KEY_LSB 3
`define WDWU_SEL_MSB 2
`define WDWU_KEY_EN 5'h0A
`define WDWU_KEY_DIS 5'h15

// Status and cause bit positions
`define WDWU_STAT_PDF 0
`define WDWU_STAT_TO 1
`define WDWU_STAT_SLEEP 2
`define WDWU_CAUSE_KEY 0

// Counter shape and delay
`define WDWU_CNT_W 15
`define WDWU_CNT_MAX 15'h7FFF
`define WDWU_SEL_TOP 3'h7
`define WDWU_KEY_DLY 4

`endif

// ---- inc/wdwu_pkg.sv ----
package wdwu_pkg;
   typedef enum logic {WDWU_RUN, WDWU_SLEEP} wdwu_state_t;
   typedef logic [7:0] wdwu_byte_t;
   typedef logic [31:0] wdwu_word_t;
endpackage

// ---- src/wdwu_unit.sv ----
// What this block does
// - Sleep wakes on port edge, interrupt, overflow
// - Halt enters sleep, sets power-down flag
// - Power-up and clear-watchdog clear power-down flag
// - Sleep overflow sets timeout, clears PC, SP
// - Enabled port A falling edge wakes, resumes
// - Disabled interrupt or full stack resumes
// - Interrupt pending at halt cannot wake
// - Timeout is two to eight-plus-select ticks
// - Key disables, enables, else resets device
// - Illegal key resets after delay, sets flag
// - Key error flag set by hardware only
// - Key holds enable pattern after power-on
// - Run-mode overflow resets like power-on, timeout
// - Bad key write, clear, halt clear counter
// - Power-on reset clears program counter
// - Power-on sets port data, direction high
// - Flags encode power-on, run, sleep resets
// - Halt clears counter and timeout flag
`timescale 1ns/100ps
`include "wdwu_map.svh"

module wdwu_unit #(
   parameter int NIRQ = 4,
   parameter int KEY_DLY = `WDWU_KEY_DLY
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] wb_adr_i,
   input wire wdwu_pkg::wdwu_word_t wb_dat_i,
   output wdwu_pkg::wdwu_word_t wb_dat_o,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic wb_ack_o,
   input wire logic low_speed_rc_osc_i,
   input wire wdwu_pkg::wdwu_byte_t porta_i,
   input wire logic halt_i,
   input wire logic clear_watchdog_instruction_i,
   input wire logic [NIRQ-1:0] irq_req_i,
   input wire logic [NIRQ-1:0] irq_en_i,
   input wire logic stack_full_i,
   output logic sleep_o,
   output logic wake_resume_o,
   output logic wake_service_o,
   output logic pc_sp_clear_o,
   output logic sys_reset_o,
   output wdwu_pkg::wdwu_byte_t porta_data_o,
   output wdwu_pkg::wdwu_byte_t porta_dir_o,
   output logic power_down_flag_o,
   output logic wdt_timeout_flag_o
);
   import wdwu_pkg::*;

   function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
      hit = (adr[7:2] == ofs[7:2]);
   endfunction

   function automatic logic key_ok(input logic [4:0] key);
      key_ok = (key == `WDWU_KEY_EN) || (key == `WDWU_KEY_DIS);
   endfunction

   function automatic logic [`WDWU_CNT_W-1:0] limit(input logic [2:0] sel);
      limit = `WDWU_CNT_MAX >> (`WDWU_SEL_TOP - sel);
   endfunction

   wdwu_state_t state_q;
   wdwu_byte_t ctrl_q, wake_en_q, pa_data_q, pa_dir_q, dat_q;
   wdwu_byte_t pa_sync1_q, pa_sync2_q, pa_prev_q;
   logic [1:0] low_speed_rc_osc_sync_q;
   logic low_speed_rc_osc_prev_q, ack_q, sys_rst_q, pdf_q, to_q, key_flag_q;
   logic wake_res_q, wake_svc_q, pc_sp_q;
   logic [`WDWU_CNT_W-1:0] cnt_q;
   logic [7:0] kdly_q;
   logic [NIRQ-1:0] irq_armed_q;

   logic init, req, wr, low_speed_rc_osc_tick, wdt_on, key_bad, bad_wr;
   logic wdt_ovf, run_ovf, slp_ovf, key_fire, soft_rst, halt_ev;
   logic sleeping, pa_wake, irq_wake, service_ok, wake_any;
   logic [2:0] sel;
   logic [4:0] key;
   wdwu_byte_t pa_fall;
   logic [NIRQ-1:0] irq_hit;

   // Internal resets restore power-on values except the cause flags
   assign init = rst_i | sys_rst_q;
   assign req = wb_cyc_i & wb_stb_i;
   // Writes land on the edge where ack is seen by the master
   assign wr = req & wb_we_i & ack_q & wb_sel_i[0];
   assign key = ctrl_q[`WDWU_KEY_MSB:`WDWU_KEY_LSB];
   assign sel = ctrl_q[`WDWU_SEL_MSB:0];
   assign wdt_on = (key == `WDWU_KEY_EN);
   assign key_bad = !key_ok(key);
   assign bad_wr = wr & hit(wb_adr_i, `WDWU_OFS_CTRL)
      & !key_ok(wb_dat_i[`WDWU_KEY_MSB:`WDWU_KEY_LSB]);
   assign sleeping = (state_q == WDWU_SLEEP);
   assign halt_ev = halt_i & !sleeping;
   assign low_speed_rc_osc_tick = low_speed_rc_osc_sync_q[1] & ~low_speed_rc_osc_prev_q;
   assign wdt_ovf = wdt_on & low_speed_rc_osc_tick & (cnt_q >= limit(sel));
   assign run_ovf = wdt_ovf & !sleeping;
   assign slp_ovf = wdt_ovf & sleeping;
   assign key_fire = key_bad & low_speed_rc_osc_tick
      & (kdly_q == 8'(KEY_DLY - 1));
   assign soft_rst = run_ovf | key_fire;
   assign pa_fall = pa_prev_q & ~pa_sync2_q & wake_en_q;
   assign pa_wake = |pa_fall;
   assign irq_hit = irq_req_i & irq_armed_q;
   assign irq_wake = |irq_hit;
   assign service_ok = (|(irq_hit & irq_en_i)) & !stack_full_i;
   assign wake_any = sleeping & (pa_wake | irq_wake | slp_ovf);

   assign wb_ack_o = ack_q;
   assign wb_dat_o = {24'h000000, dat_q};
   assign sleep_o = sleeping;
   assign wake_resume_o = wake_res_q;
   assign wake_service_o = wake_svc_q;
   assign pc_sp_clear_o = pc_sp_q;
   assign sys_reset_o = sys_rst_q;
   assign porta_data_o = pa_data_q;
   assign porta_dir_o = pa_dir_q;
   assign power_down_flag_o = pdf_q;
   assign wdt_timeout_flag_o = to_q;

   // Pin synchronisers; edges only look past the second stage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         low_speed_rc_osc_sync_q <= 2'h0;
         low_speed_rc_osc_prev_q <= 1'b0;
         pa_sync1_q <= 8'hFF;
         pa_sync2_q <= 8'hFF;
         pa_prev_q <= 8'hFF;
      end else begin
         low_speed_rc_osc_sync_q <= {low_speed_rc_osc_sync_q[0], low_speed_rc_osc_i};
         low_speed_rc_osc_prev_q <= low_speed_rc_osc_sync_q[1];
         pa_sync1_q <= porta_i;
         pa_sync2_q <= pa_sync1_q;
         pa_prev_q <= pa_sync2_q;
      end
   end

   // Bus slave: one wait state, unmapped reads return zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= 8'h00;
      end else begin
         ack_q <= req & !ack_q;
         if (req & !ack_q) begin
            if (hit(wb_adr_i, `WDWU_OFS_CTRL))
               dat_q <= ctrl_q;
            else if (hit(wb_adr_i, `WDWU_OFS_CAUSE))
               dat_q <= {7'h00, key_flag_q};
            else if (hit(wb_adr_i, `WDWU_OFS_STAT))
               dat_q <= {5'h00, sleeping, to_q, pdf_q};
            else if (hit(wb_adr_i, `WDWU_OFS_WAKE_EN))
               dat_q <= wake_en_q;
            else if (hit(wb_adr_i, `WDWU_OFS_PA_DATA))
               dat_q <= pa_data_q;
            else if (hit(wb_adr_i, `WDWU_OFS_PA_DIR))
               dat_q <= pa_dir_q;
            else
               dat_q <= 8'h00;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (init)
         ctrl_q <= `WDWU_CTRL_RST;
      else if (wr & hit(wb_adr_i, `WDWU_OFS_CTRL))
         ctrl_q <= wb_dat_i[7:0];
   end

   always_ff @(posedge clk_i) begin
      if (init) begin
         pa_data_q <= `WDWU_PA_RST;
         pa_dir_q <= `WDWU_PA_RST;
         wake_en_q <= `WDWU_WAKE_EN_RST;
      end else begin
         if (wr & hit(wb_adr_i, `WDWU_OFS_PA_DATA))
            pa_data_q <= wb_dat_i[7:0];
         if (wr & hit(wb_adr_i, `WDWU_OFS_PA_DIR))
            pa_dir_q <= wb_dat_i[7:0];
         if (wr & hit(wb_adr_i, `WDWU_OFS_WAKE_EN))
            wake_en_q <= wb_dat_i[7:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (init | halt_ev | clear_watchdog_instruction_i | bad_wr | wdt_ovf)
         cnt_q <= '0;
      else if (wdt_on & low_speed_rc_osc_tick)
         cnt_q <= cnt_q + 1'b1;
   end

   always_ff @(posedge clk_i) begin
      if (init | !key_bad)
         kdly_q <= 8'h00;
      else if (low_speed_rc_osc_tick)
         kdly_q <= kdly_q + 8'h01;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i)
         sys_rst_q <= 1'b0;
      else
         sys_rst_q <= soft_rst;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i)
         pc_sp_q <= 1'b1;
      else
         pc_sp_q <= soft_rst | slp_ovf;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i)
         pdf_q <= 1'b0;
      else if (halt_ev)
         pdf_q <= 1'b1;
      else if (clear_watchdog_instruction_i)
         pdf_q <= 1'b0;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i)
         to_q <= 1'b0;
      else if (wdt_ovf)
         to_q <= 1'b1;
      else if (halt_ev)
         to_q <= 1'b0;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i)
         key_flag_q <= 1'b0;
      else if (key_fire)
         key_flag_q <= 1'b1;
      else if (wr & hit(wb_adr_i, `WDWU_OFS_CAUSE)
               & !wb_dat_i[`WDWU_CAUSE_KEY])
         key_flag_q <= 1'b0;
   end

   always_ff @(posedge clk_i) begin
      if (init)
         irq_armed_q <= '0;
      else if (halt_ev)
         irq_armed_q <= ~irq_req_i;
   end

   always_ff @(posedge clk_i) begin
      if (init)
         state_q <= WDWU_RUN;
      else begin
         unique case (state_q)
            WDWU_RUN: begin
               if (halt_i)
                  state_q <= WDWU_SLEEP;
            end
            WDWU_SLEEP: begin
               if (wake_any)
                  state_q <= WDWU_RUN;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (init) begin
         wake_res_q <= 1'b0;
         wake_svc_q <= 1'b0;
      end else begin
         wake_res_q <= wake_any & !slp_ovf & !(irq_wake & service_ok);
         wake_svc_q <= wake_any & !slp_ovf & irq_wake & service_ok;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // Overflow wins over halt for the timeout flag
   sequence s_halt;
      halt_ev && !sys_rst_q && !wdt_ovf;
   endsequence
   sequence s_asleep;
      sleep_o && power_down_flag_o && !wdt_timeout_flag_o;
   endsequence
   sequence s_key_fire;
      key_fire;
   endsequence
   sequence s_key_done;
      sys_reset_o && key_flag_q ##1 ctrl_q == `WDWU_CTRL_RST;
   endsequence

   AST_HALT_PDF: assert property (s_halt |=> s_asleep)
      else $error("halt did not enter sleep with flags");
   AST_CLR_PDF: assert property (
      clear_watchdog_instruction_i && !halt_ev |=> !power_down_flag_o)
      else $error("clear-watchdog left power-down flag set");
   AST_SLP_OVF: assert property (slp_ovf && !sys_rst_q |=>
      pc_sp_clear_o && wdt_timeout_flag_o && power_down_flag_o
      && !sys_reset_o && !sleep_o)
      else $error("sleep overflow wake wrong");
   AST_PA_WAKE: assert property (sleeping && pa_wake && !slp_ovf
      && !irq_wake && !sys_rst_q |=> wake_resume_o && !sleep_o)
      else $error("port A wake did not resume");
   AST_IRQ_RESUME: assert property (sleeping && irq_wake
      && !service_ok && !slp_ovf && !sys_rst_q
      |=> wake_resume_o && !wake_service_o)
      else $error("blocked interrupt wake did not resume");
   AST_IRQ_MASK: assert property (sleeping && !irq_wake
      && !pa_wake && !wdt_ovf && !sys_rst_q |=> sleep_o)
      else $error("device woke without a source");
   AST_TICK: assert property (wdt_on && low_speed_rc_osc_tick && !wdt_ovf
      && !init && !halt_ev && !clear_watchdog_instruction_i && !bad_wr
      |=> cnt_q == $past(cnt_q) + 1'b1)
      else $error("counter missed a slow tick");
   AST_DIS: assert property (key == `WDWU_KEY_DIS |=> !sys_reset_o
      && (cnt_q == 0 || $stable(cnt_q)))
      else $error("disabled watchdog moved or reset");
   AST_KEY_RST: assert property (s_key_fire |=> s_key_done)
      else $error("illegal key did not reset with flag");
   AST_KEY_HOLD: assert property (key_flag_q && !(wr
      && hit(wb_adr_i, `WDWU_OFS_CAUSE) && !wb_dat_i[0])
      |=> key_flag_q)
      else $error("key error flag lost without clear");
   AST_RUN_OVF: assert property (run_ovf |=> sys_reset_o
      && wdt_timeout_flag_o ##1 porta_dir_o == `WDWU_PA_RST)
      else $error("run overflow did not reset device");
   AST_CNT_CLR: assert property (
      (clear_watchdog_instruction_i || halt_ev) |=> cnt_q == 0)
      else $error("counter not cleared");
   AST_POR: assert property ($past(rst_i) |-> pc_sp_clear_o
      && porta_data_o == `WDWU_PA_RST && ctrl_q == `WDWU_CTRL_RST)
      else $error("power-on values wrong");
endmodule

// ---- verif/test_watchdog_wakeup_reset_unit.sv ----
`timescale 1ns/100ps
module test_watchdog_wakeup_reset_unit;
   import wdwu_pkg::*;
   logic clk_i = 0, rst_i = 1, we = 0, cyc = 0, stb = 0, ack, slow = 0;
   logic [7:0] adr = 0;
   wdwu_word_t dat = 0, rdat;
   wdwu_byte_t porta = 8'hFF, pad, pdir;
   logic [3:0] irq_req = 0, irq_en = 0;
   logic sf = 0, sleep, wres, wsrv, pcc, srst, power_down_flag, tof, halt, clr;
   logic halt_req = 0, clr_req = 0, kick_en = 0;
   int err_count = 0, n_tests = 0, cyc_n = 0, took, c0;
   int cnt[4] = '{default: 0};
   wdwu_word_t exp_q[$], r;
   string nm_q[$];
   logic [31:0] seed = 83384;
   logic [2:0] b;
   logic [7:0] ra[7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C};
   logic [7:0] rv[7] = '{8'h53, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00};

   wdwu_unit dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
      .wb_dat_i(dat), .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(4'hF),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
      .low_speed_rc_osc_i(slow), .porta_i(porta), .halt_i(halt),
      .clear_watchdog_instruction_i(clr), .irq_req_i(irq_req),
      .irq_en_i(irq_en), .stack_full_i(sf), .sleep_o(sleep),
      .wake_resume_o(wres), .wake_service_o(wsrv), .pc_sp_clear_o(pcc),
      .sys_reset_o(srst), .porta_data_o(pad), .porta_dir_o(pdir),
      .power_down_flag_o(power_down_flag), .wdt_timeout_flag_o(tof));
   wdwu_cpu_model cpu (.clk_i(clk_i), .rst_i(rst_i), .sleep_i(sleep),
      .halt_req_i(halt_req), .clr_req_i(clr_req), .kick_en_i(kick_en),
      .halt_o(halt), .clear_watchdog_instruction_o(clr));

   initial forever #50 clk_i = ~clk_i;
   // Slow ticks every two cycles keep the long counts short
   always @(posedge clk_i) slow <= ~slow;

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic chk(input string nm, input logic [31:0] e, g);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic end_of_test();
      $display("tests %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // Read results are matched in order of issue
   always @(posedge clk_i) begin
      cyc_n++;
      if (srst) cnt[0]++;
      if (pcc) cnt[1]++;
      if (wres) cnt[2]++;
      if (wsrv) cnt[3]++;
      if (ack === 1'b1 && !we) begin
         if (exp_q.size() == 0) chk("spare ack", 0, 1);
         else chk(nm_q.pop_front(), exp_q.pop_front(), rdat);
      end
      // Run is about 71000 cycles
      if (cyc_n >= 100000) begin
         err_count++;
         end_of_test();
      end
   end

   task automatic wb(input logic [7:0] a, input logic w, input wdwu_word_t d);
      @(posedge clk_i);
      adr <= a;
      we <= w;
      dat <= d;
      cyc <= 1;
      stb <= 1;
      do @(posedge clk_i); while (ack !== 1'b1);
      cyc <= 0;
      stb <= 0;
   endtask

   task automatic rd(input logic [7:0] a, input wdwu_word_t e, string nm);
      exp_q.push_back(e);
      nm_q.push_back(nm);
      wb(a, 0, 0);
   endtask

   task automatic ev(input int i, lim, hit, input string nm);
      int base;
      base = cnt[i];
      took = 0;
      while (cnt[i] == base && took < lim) begin
         @(posedge clk_i);
         took++;
      end
      chk(nm, hit, cnt[i] - base);
   endtask

   task automatic halt_now();
      repeat (2) @(posedge clk_i);
      halt_req <= 1;
      @(posedge clk_i);
      halt_req <= 0;
      repeat (2) @(posedge clk_i);
      chk("sleep_o", 1, sleep);
      chk("power_down_flag_o", 1, power_down_flag);
   endtask

   task automatic kick();
      @(posedge clk_i);
      clr_req <= 1;
      @(posedge clk_i);
      clr_req <= 0;
   endtask

   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 0;
      @(posedge clk_i);
      chk("porta_data_o", 8'hFF, pad);
      chk("porta_dir_o", 8'hFF, pdir);
      for (int i = 0; i < 7; i++) rd(ra[i], rv[i], "reset value");
      r = rnd();
      wb(8'h10, 1, r);
      rd(8'h10, {24'h0, r[7:0]}, "porta data");
      chk("porta_data_o", r[7:0], pad);
      wb(8'h00, 1, 32'hA8);
      rd(8'h00, 32'hA8, "control");
      b = r[10:8];
      wb(8'h0C, 1, 32'h1 << b);
      halt_now();
      rd(8'h08, 32'h5, "status asleep");
      porta <= ~(8'h1 << (b ^ 3'h1));
      ev(2, 12, 0, "masked pin");
      porta <= ~((8'h1 << b) | (8'h1 << (b ^ 3'h1)));
      ev(2, 12, 1, "port wake");
      repeat (2) @(posedge clk_i);
      chk("sleep_o", 0, sleep);
      rd(8'h08, 32'h1, "status woken");
      kick();
      rd(8'h08, 32'h0, "pdf cleared");
      for (int k = 0; k < 3; k++) begin
         irq_req <= 0;
         porta <= 8'hFF;
         irq_en <= (k > 0) ? 4'hF : 4'h0;
         sf <= (k == 1);
         halt_now();
         irq_req <= 4'h1 << k;
         ev((k == 2) ? 3 : 2, 12, 1, "irq wake");
      end
      irq_req <= 4'h8;
      sf <= 0;
      porta <= 8'hFF;
      halt_now();
      ev(3, 20, 0, "pending irq");
      porta <= 8'h00;
      ev(2, 12, 1, "port exit");
      irq_req <= 0;
      for (int s = 0; s < 3; s++) begin
         b = (s == 2) ? 3'h7 : s[2:0];
         wb(8'h00, 1, 32'h50 | b);
         kick();
         ev(0, 2 ** (9 + b) + 40, 1, "run timeout");
         chk("period", 1, took >= 2 ** (9 + b) - 4 &&
            took <= 2 ** (9 + b) + 12);
         rd(8'h08, 32'h2, "status run reset");
         chk("port data reset", 8'hFF, pad);
         chk("port dir reset", 8'hFF, pdir);
      end
      wb(8'h00, 1, 32'h50);
      halt_now();
      rd(8'h08, 32'h5, "status halt");
      c0 = cnt[0];
      ev(1, 600, 1, "sleep timeout");
      chk("sleep period", 1, took >= 490 && took <= 530);
      chk("no full reset", c0, cnt[0]);
      chk("wdt_timeout_flag_o", 1, tof);
      rd(8'h08, 32'h3, "status sleep reset");
      kick_en <= 1;
      wb(8'h00, 1, 32'h50);
      c0 = cnt[0];
      repeat (3000) @(posedge clk_i);
      kick_en <= 0;
      chk("kept alive", c0, cnt[0]);
      wb(8'h00, 1, 32'h00);
      ev(0, 40, 1, "key reset");
      rd(8'h04, 32'h1, "key flag");
      wb(8'h04, 1, 32'h1);
      rd(8'h04, 32'h1, "flag kept");
      wb(8'h04, 1, 32'h0);
      rd(8'h04, 32'h0, "flag cleared");
      rd(8'h00, 32'h53, "control reinit");
      repeat (2) @(posedge clk_i);
      end_of_test();
   end
endmodule

// ---- verif/wdwu_cpu_model.sv ----
`timescale 1ns/100ps
module wdwu_cpu_model #(
   parameter int KICK = 200
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic sleep_i,
   input wire logic halt_req_i,
   input wire logic clr_req_i,
   input wire logic kick_en_i,
   output logic halt_o,
   output logic clear_watchdog_instruction_o
);
   int cnt_q;
   // A halted core issues no instructions
   always_ff @(posedge clk_i) begin
      if (rst_i || !kick_en_i || sleep_i) begin
         cnt_q <= 0;
      end else begin
         cnt_q <= (cnt_q == KICK - 1) ? 0 : cnt_q + 1;
      end
   end
   always_ff @(posedge clk_i) begin
      halt_o <= halt_req_i && !sleep_i && !rst_i;
   end
   always_ff @(posedge clk_i) begin
      clear_watchdog_instruction_o <= !rst_i && !sleep_i &&
         (clr_req_i || (kick_en_i && cnt_q == KICK - 1));
   end
endmodule
